// *** hdl/fbci_host.sv ***
/*
  fbci_host: host controller for a parallel nor flash,
  its strobes and unlock command sequences.
  assumes software on a plain register port and the flash on pins.
*/
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// RL1 - writes hold chip select, strobe low, gate high
// RL2 - erase one sector, several, or whole chip; host erases one sector per sequence or the whole chip, not several
// RL3 - identification mode returns codes on low lines
// RL4 - address idle over 250ns sleeps device
// RL5 - sleeping device keeps last data readable
// RL6 - width pin selects 16-bit or 8-bit path
// RL7 - width level set before enabling, kept stable
// RL8 - high voltage reset temporarily unprotects sectors
// RL9 - gate high releases device data outputs
// RL10 - standby, then wait full access time
// RL11 - deselect does not stop embedded operation
// RL12 - protected sectors reject program and erase
// RL13 - protect all sectors before first unprotect
// RL14 - wrong command write aborts to array read
// RL15 - address captured on later falling strobe
// RL16 - data captured on earlier rising strobe
// RL17 - single F0 write resets to read
// RL18 - program is four writes with unlocks
// RL19 - chip erase is six writes
// RL20 - sector erase sixth write 30 to sector
// RL21 - B0 write suspends sector erase
// RL22 - 30 write resumes suspended erase
// RL23 - suspend/resume only valid in right state
// RL24 - reset ignored during embedded operation
// RL25 - identification fourth cycle is a read
module fbci_host
  import fbci_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic flash_ce_n,
  output logic flash_we_n,
  output logic flash_oe_n,
  output logic flash_reset_n,
  output logic flash_reset_hv,
  output logic flash_wide,
  output logic [ADDR_W-1:0] flash_a,
  output logic shared_top_pin_o,
  output logic shared_top_pin_oe,
  input wire logic shared_top_pin_i,
  input wire logic [DATA_W-2:0] flash_dq_i,
  output logic [DATA_W-2:0] flash_dq_o,
  output logic flash_dq_oe,
  input wire logic flash_ready
);
  typedef enum {HS_IDLE, HS_ISSUE, HS_WAIT, HS_BUSY} fbci_hs_t;
  fbci_hs_t st_r; // sequencer state
  logic [5:0] ctrl_r; // op, go, wide, hv
  logic [ADDR_W-1:0] addr_r; // target address
  logic [DATA_W-1:0] wdata_r; // program value
  logic [DATA_W-1:0] rdata_r; // last read value
  logic [2:0] op_r; // operation in flight
  logic [2:0] step_r; // bus cycle index in sequence
  logic busy_r; // sequence running
  logic err_r; // sticky refused-command flag
  logic ersusp_r; // erase suspended
  logic erasing_r; // sector erase running
  logic asel_r; // device in identification mode
  logic embedded_r; // embedded algorithm running on device
  logic [31:0] rd_q_r; // read data, one cycle after strobe
  logic cyc_start;
  logic cyc_busy;
  logic cyc_done;
  logic [DATA_W-1:0] cyc_rdata;
  logic [DATA_W-1:0] cyc_dq_out;
  logic cyc_dq_oe;
  logic [DATA_W-1:0] dq_sync;
  logic ready_sync;
  logic [DATA_W-1:0] dq_raw;
  logic [ADDR_W-1:0] seq_addr;
  logic [DATA_W-1:0] seq_data;
  logic seq_write;
  logic [2:0] seq_len;
  logic [ADDR_W-1:0] cyc_a;
  // unpack software control
  wire [2:0] ctrl_op = ctrl_r[CTRL_OP_LSB +: 3];
  wire [2:0] new_op = reg_wdata[CTRL_OP_LSB +: 3]; // op being requested now
  wire ctrl_wide = ctrl_r[CTRL_WIDE_BIT];
  wire go_wr = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO_BIT];
  // width taken only while idle (see RL7)
  wire ctrl_wr_ok = reg_wr && (reg_addr == REG_CTRL) && !busy_r;
  // unlock addresses follow the width select (see RL18)
  wire [ADDR_W-1:0] ua = ctrl_wide ? ADDR_W'(UNLOCK_A_WORD) : ADDR_W'(UNLOCK_A_BYTE);
  wire [ADDR_W-1:0] ub = ctrl_wide ? ADDR_W'(UNLOCK_B_WORD) : ADDR_W'(UNLOCK_B_BYTE);
  // judged on the new op, ctrl_r still holds the old one (see RL23)
  wire op_legal = (new_op == OP_SUSPEND) ? erasing_r :
                  (new_op == OP_RESUME) ? ersusp_r :
                  (new_op == OP_RESET) ? !embedded_r : // see RL24
                  (new_op == OP_READ) ? !embedded_r || ersusp_r :
                  !embedded_r; // device ignores commands while busy (see RL11)
  wire [DATA_W-1:0] pin_in = {shared_top_pin_i, flash_dq_i};
  // bus cycle count per operation
  assign seq_len = (ctrl_op == OP_PROGRAM) ? 3'd4 :
                   (ctrl_op == OP_CHIP_ERASE) ? 3'd6 : // see RL19
                   (ctrl_op == OP_SECTOR_ERASE) ? 3'd6 : // see RL2
                   (ctrl_op == OP_AUTOSELECT) ? 3'd4 :
                   3'd1;
  // sequence step table, address and data per step
  always_comb
  begin
    seq_addr = addr_r;
    seq_data = wdata_r;
    seq_write = 1'b1;
    case (op_r)
      OP_READ:
      begin
        // in identification mode this returns the code word (see RL3)
        seq_write = 1'b0;
      end
      OP_RESET:
        seq_data = DATA_W'(CMD_RESET); // see RL17
      OP_SUSPEND:
        seq_data = DATA_W'(CMD_SUSPEND); // see RL21
      OP_RESUME:
        seq_data = DATA_W'(CMD_RESUME); // see RL22
      default:
      begin
        case (step_r)
          3'd0:
          begin
            seq_addr = ua;
            seq_data = DATA_W'(CMD_UNLOCK1);
          end
          3'd1:
          begin
            seq_addr = ub;
            seq_data = DATA_W'(CMD_UNLOCK2);
          end
          3'd2:
          begin
            seq_addr = ua;
            seq_data = (op_r == OP_PROGRAM) ? DATA_W'(CMD_PROGRAM) : // see RL18
                       (op_r == OP_AUTOSELECT) ? DATA_W'(CMD_AUTOSELECT) :
                       DATA_W'(CMD_ERASE_SETUP);
          end
          3'd3:
          begin
            // program target, the identification read, or for erases the second AA unlock to ua (see RL25)
            seq_addr = (op_r == OP_PROGRAM || op_r == OP_AUTOSELECT) ? addr_r : ua;
            seq_data = (op_r == OP_PROGRAM) ? wdata_r : DATA_W'(CMD_UNLOCK1);
            seq_write = (op_r != OP_AUTOSELECT);
          end
          3'd4:
          begin
            seq_addr = ub;
            seq_data = DATA_W'(CMD_UNLOCK2);
          end
          default:
          begin
            // sector address for sector erase (see RL20)
            seq_addr = (op_r == OP_SECTOR_ERASE) ? addr_r : ua;
            seq_data = (op_r == OP_SECTOR_ERASE) ? DATA_W'(CMD_SECTOR_ERASE) :
                       DATA_W'(CMD_CHIP_ERASE);
          end
        endcase
      end
    endcase
  end
  assign cyc_start = (st_r == HS_ISSUE);
  // synchronise pin inputs before use
  fbci_sync #(.W(DATA_W + 1)) u_sync
  (
    .clk(clk),
    .arst_n(arst_n),
    .din({flash_ready, pin_in}),
    .dout({ready_sync, dq_raw})
  );
  // byte mode: low eight lines only (see RL6)
  assign dq_sync = ctrl_wide ? dq_raw : {8'h00, dq_raw[7:0]};
  fbci_cycle u_cycle
  (
    .clk(clk),
    .arst_n(arst_n),
    .start(cyc_start),
    .is_write(seq_write),
    .addr(seq_addr),
    .wdata(seq_data),
    .dq_sync(dq_sync),
    .busy(cyc_busy),
    .done(cyc_done),
    .rdata(cyc_rdata),
    .ce_n(flash_ce_n),
    .we_n(flash_we_n),
    .oe_n(flash_oe_n),
    .a_out(cyc_a),
    .dq_out(cyc_dq_out),
    .dq_oe(cyc_dq_oe)
  );
  // top pin is data 15 or address lsb (see RL6)
  assign flash_a = ctrl_wide ? cyc_a : {1'b0, cyc_a[ADDR_W-1:1]};
  assign shared_top_pin_o = ctrl_wide ? cyc_dq_out[DATA_W-1] : cyc_a[0];
  assign shared_top_pin_oe = ctrl_wide ? cyc_dq_oe : 1'b1;
  assign flash_dq_o = cyc_dq_out[DATA_W-2:0];
  assign flash_dq_oe = cyc_dq_oe; // released with gate high (see RL9)
  assign flash_wide = ctrl_wide;
  assign flash_reset_n = 1'b1; // standby whenever ce is high (see RL10)
  // high voltage request for temporary unprotect (see RL8)
  assign flash_reset_hv = ctrl_r[CTRL_HV_BIT];
  // register write path
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_r <= CTRL_RST;
      addr_r <= '0;
      wdata_r <= '0;
    end
    else if (reg_wr && !busy_r)
    begin
      if (ctrl_wr_ok)
        ctrl_r <= {reg_wdata[CTRL_HV_BIT], reg_wdata[CTRL_WIDE_BIT], 1'b0, reg_wdata[2:0]};
      if (reg_addr == REG_ADDR)
        addr_r <= reg_wdata[ADDR_W-1:0];
      if (reg_addr == REG_WDATA)
        wdata_r <= reg_wdata[DATA_W-1:0];
    end
  end
  // sequencer of command bus cycles
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= HS_IDLE;
      op_r <= OP_READ;
      step_r <= '0;
      busy_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      case (st_r)
        HS_IDLE:
        begin
          if (go_wr && !busy_r)
          begin
            if (op_legal)
            begin
              op_r <= reg_wdata[2:0];
              step_r <= '0;
              busy_r <= 1'b1;
              st_r <= HS_ISSUE;
            end
            else
              err_r <= 1'b1; // refused; never sends an out-of-order write (see RL14)
          end
          else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STAT_ERR_BIT])
            err_r <= 1'b0;
        end
        HS_ISSUE:
          st_r <= HS_WAIT;
        HS_WAIT:
        begin
          if (cyc_done)
          begin
            if (!seq_write)
              rdata_r <= cyc_rdata;
            if (step_r == seq_len - 3'd1)
            begin
              st_r <= HS_BUSY;
            end
            else
            begin
              step_r <= step_r + 3'd1;
              st_r <= HS_ISSUE;
            end
          end
        end
        HS_BUSY:
        begin
          busy_r <= 1'b0;
          st_r <= HS_IDLE;
        end
        default:
          st_r <= HS_IDLE;
      endcase
    end
  end
  // device mode tracking
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      embedded_r <= 1'b0;
      erasing_r <= 1'b0;
      ersusp_r <= 1'b0;
      asel_r <= 1'b0;
    end
    else if (st_r == HS_BUSY)
    begin
      case (op_r)
        OP_PROGRAM, OP_CHIP_ERASE:
          embedded_r <= 1'b1;
        OP_SECTOR_ERASE:
        begin
          embedded_r <= 1'b1;
          erasing_r <= 1'b1;
        end
        OP_SUSPEND:
        begin
          erasing_r <= 1'b0;
          ersusp_r <= 1'b1;
        end
        OP_RESUME:
        begin
          erasing_r <= 1'b1;
          ersusp_r <= 1'b0;
        end
        OP_AUTOSELECT:
          asel_r <= 1'b1;
        OP_RESET:
          asel_r <= 1'b0;
        default:
          asel_r <= asel_r;
      endcase
    end
    else if (embedded_r && ready_sync && !ersusp_r && !cyc_busy)
    begin
      // ready high ends it, even deselected (see RL11)
      embedded_r <= 1'b0;
      erasing_r <= 1'b0;
    end
  end
  // read data one cycle after strobe
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rd_q_r <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        REG_CTRL: rd_q_r <= {26'h0, ctrl_r};
        REG_ADDR: rd_q_r <= {14'h0, addr_r};
        REG_WDATA: rd_q_r <= {16'h0, wdata_r};
        REG_RDATA: rd_q_r <= {16'h0, rdata_r};
        REG_STATUS: rd_q_r <= {28'h0, asel_r, ersusp_r, err_r, busy_r || embedded_r};
        default: rd_q_r <= '0;
      endcase
    end
    else
      rd_q_r <= '0;
  end
  assign reg_rdata = rd_q_r;
endmodule
`default_nettype wire

// *** hdl/fbci_pkg.sv ***
/*
  fbci_pkg: host controller constants.
  assumes a 50 MHz clk.
*/
package fbci_pkg;
  // clock
  localparam int CLK_MHZ = 50;
  localparam int CLK_NS = 1000 / CLK_MHZ;
  // strobe low time, rounded up
  localparam int STROBE_NS = 70;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // setup and hold time
  localparam int SETUP_NS = 20;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  // access time after standby
  localparam int ACCESS_NS = 90;
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
  // flash sleep idle time
  localparam int SLEEP_NS = 250;
  localparam int SLEEP_CYC = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  // widths
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  // command codes
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_RESUME = 8'h30;
  localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
  // unlock addresses, word/byte
  localparam logic [11:0] UNLOCK_A_WORD = 12'h555;
  localparam logic [11:0] UNLOCK_B_WORD = 12'h2aa;
  localparam logic [11:0] UNLOCK_A_BYTE = 12'haaa;
  localparam logic [11:0] UNLOCK_B_BYTE = 12'h555;
  // host operations
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_PROGRAM = 3'h2;
  localparam logic [2:0] OP_CHIP_ERASE = 3'h3;
  localparam logic [2:0] OP_SECTOR_ERASE = 3'h4;
  localparam logic [2:0] OP_SUSPEND = 3'h5;
  localparam logic [2:0] OP_RESUME = 3'h6;
  localparam logic [2:0] OP_AUTOSELECT = 3'h7;
  // register map of the controller
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h1;
  localparam logic [3:0] REG_WDATA = 4'h2;
  localparam logic [3:0] REG_RDATA = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_GO_BIT = 3;
  localparam int CTRL_WIDE_BIT = 4;
  localparam int CTRL_HV_BIT = 5;
  localparam logic [5:0] CTRL_RST = 6'h10;
  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT = 1;
  localparam int STAT_ERSUSP_BIT = 2;
  localparam int STAT_ASEL_BIT = 3;
endpackage

// *** hdl/fbci_sync.sv ***
/*
  fbci_sync: two-stage synchroniser.
  assumes inputs asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fbci_sync
#(
  parameter int W = 1
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_r; // first stage, read only by second
  // two stages, constants at reset
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_r <= '0;
      dout <= '0;
    end
    else
    begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

// *** hdl/fbci_cycle.sv ***
/*
  fbci_cycle: one flash bus cycle.
  assumes inputs held while busy.
*/
`timescale 1ns/1ps
`default_nettype none
module fbci_cycle
  import fbci_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic is_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] dq_sync,
  output logic busy,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic ce_n,
  output logic we_n,
  output logic oe_n,
  output logic [ADDR_W-1:0] a_out,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe
);
  typedef enum {CY_IDLE, CY_SETUP, CY_STROBE, CY_HOLD} fbci_cy_t;
  fbci_cy_t st_r; // phase of the bus cycle
  logic [CNT_W-1:0] cnt_r; // phase timer
  logic wr_r; // latched kind
  wire cnt_zero = (cnt_r == '0);
  wire [CNT_W-1:0] setup_c = CNT_W'(SETUP_CYC - 1);
  wire [CNT_W-1:0] strobe_c = CNT_W'(STROBE_CYC + ACCESS_CYC - 1);
  wire [CNT_W-1:0] hold_c = CNT_W'(SETUP_CYC - 1);
  assign busy = (st_r != CY_IDLE);
  // phase sequencer
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= CY_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      ce_n <= 1'b1;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      a_out <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      rdata <= '0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (!cnt_zero)
        cnt_r <= cnt_r - 1'b1;
      case (st_r)
        CY_IDLE:
        begin
          if (start)
          begin
            st_r <= CY_SETUP;
            cnt_r <= setup_c;
            wr_r <= is_write;
            a_out <= addr;
            dq_out <= wdata;
            dq_oe <= is_write;
          end
        end
        CY_SETUP:
        begin
          // write: ce and we low, gate high (see RL1); address latched on later fall (see RL15)
          if (cnt_zero)
          begin
            st_r <= CY_STROBE;
            cnt_r <= strobe_c;
            ce_n <= 1'b0;
            we_n <= !wr_r;
            oe_n <= wr_r; // see RL1
          end
        end
        CY_STROBE:
        begin
          if (cnt_zero)
          begin
            // both strobes rise together, data stable across it (see RL16)
            st_r <= CY_HOLD;
            cnt_r <= hold_c;
            ce_n <= 1'b1;
            we_n <= 1'b1;
            oe_n <= 1'b1;
            if (!wr_r)
              rdata <= dq_sync; // gate release also frees the bus (see RL9)
          end
        end
        CY_HOLD:
        begin
          if (cnt_zero)
          begin
            st_r <= CY_IDLE;
            dq_oe <= 1'b0;
            done <= 1'b1;
          end
        end
        default:
          st_r <= CY_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** verif/fbci_host_properties.sv ***
/*
  fbci_host_chk: pin protocol assertions.
  assumes a bind onto fbci_host.
*/
`timescale 1ns/1ps
`default_nettype none
module fbci_host_chk
  import fbci_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flash_ce_n,
  input wire logic flash_we_n,
  input wire logic flash_oe_n,
  input wire logic flash_wide,
  input wire logic [ADDR_W-1:0] flash_a,
  input wire logic [DATA_W-2:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic shared_top_pin_oe
);
  // one domain
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_wr_gate;
    !flash_we_n |-> !flash_ce_n && flash_oe_n;
  endproperty
  a_wr_gate: assert property (p_wr_gate)
    else $error("bad write gate");
  property p_wr_len;
    $fell(flash_we_n) |-> !flash_we_n[*4];
  endproperty
  a_wr_len: assert property (p_wr_len)
    else $error("short write");
  property p_wr_end;
    $fell(flash_we_n) |-> ##[4:20] $rose(flash_we_n);
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write stuck");
  property p_data_hold;
    !$past(flash_we_n) |-> flash_dq_oe && $stable(flash_dq_o);
  endproperty
  a_data_hold: assert property (p_data_hold)
    else $error("data moved");
  property p_addr_hold;
    !$past(flash_ce_n) |-> $stable(flash_a);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved");
  property p_no_fight;
    !flash_oe_n |-> !flash_dq_oe;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("bus fight");
  property p_top_pin;
    flash_wide ? (flash_oe_n || !shared_top_pin_oe) : shared_top_pin_oe;
  endproperty
  a_top_pin: assert property (p_top_pin)
    else $error("top pin misdriven");
  property p_wide_still;
    !flash_ce_n |-> $stable(flash_wide);
  endproperty
  a_wide_still: assert property (p_wide_still)
    else $error("width moved");
  property p_rd_access;
    $fell(flash_oe_n) |-> !flash_oe_n[*5];
  endproperty
  a_rd_access: assert property (p_rd_access)
    else $error("short read");
endmodule
bind fbci_host fbci_host_chk u_chk (.*);
`default_nettype wire

// *** verif/fbci_flash_model.sv ***
/*
  fbci_flash_model: nor flash with a write log.
  assumes the bench resolves the data bus.
*/
`timescale 1ns/1ps
`default_nettype none
module fbci_flash_model
  import fbci_pkg::*;
#(
  parameter logic [7:0] ID_CODE = 8'h5e, // arbitrary value
  parameter int PROG_STEPS = 20,
  parameter int ERASE_STEPS = 400
)
(
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic reset_hv,
  input wire logic wide,
  input wire logic [ADDR_W-1:0] a,
  input wire logic [DATA_W-1:0] dq,
  output logic [DATA_W-1:0] q,
  output logic q_oe,
  output logic ready
);
  logic [ADDR_W-1:0] wa[$]; // write log, read by the bench
  logic [DATA_W-1:0] wd[$];
  logic [DATA_W-1:0] mem[int];
  logic [ADDR_W-1:0] la;
  logic in_wr = 1'b0;
  int st = 0; // unlock step
  int left = 0; // embedded op steps to go
  int saved = 0; // steps parked by a suspend
  bit idm = 1'b0;
  bit sect = 1'b0;
  // command decode, else back to read
  function automatic void cmd(logic [11:0] ad, logic [7:0] d);
    logic [11:0] u;
    logic [11:0] v;
    u = wide ? 12'h555 : 12'haaa;
    v = wide ? 12'h2aa : 12'h555;
    if (left > 0)
    begin
      if (sect && d == 8'hb0)
      begin
        saved = left;
        left = 0;
      end
    end // else ignored
    else if (saved > 0 && st == 0 && d == 8'h30)
    begin
      left = saved;
      saved = 0;
    end
    else if (d == 8'hf0)
    begin
      st = 0;
      idm = 1'b0;
    end
    else
      case (st)
        0: st = (ad == u && d == 8'haa) ? 1 : 0;
        1: st = (ad == v && d == 8'h55) ? 2 : 0;
        2:
        begin
          idm = ad == u && d == 8'h90;
          st = ad != u ? 0 : d == 8'ha0 ? 6 : d == 8'h80 ? 3 : 0;
        end
        3: st = (ad == u && d == 8'haa) ? 4 : 0;
        4: st = (ad == v && d == 8'h55) ? 5 : 0;
        5:
        begin
          sect = d == 8'h30;
          if (sect || (d == 8'h10 && ad == u))
            left = ERASE_STEPS;
          if (!sect && left > 0)
            mem.delete();
          st = 0;
        end
        default:
        begin
          // top sector protected unless hv
          if (la[ADDR_W-1:12] != 6'h3f || reset_hv)
            mem[int'(la)] = dq;
          left = PROG_STEPS;
          st = 0;
        end
      endcase
  endfunction
  // address on whichever strobe falls last
  always @(negedge ce_n or negedge we_n)
    if (!ce_n && !we_n && oe_n)
    begin
      la = wide ? a : {a[ADDR_W-2:0], dq[15]};
      in_wr = 1'b1;
    end
  // data on whichever strobe rises first
  always @(posedge ce_n or posedge we_n)
    if (in_wr)
    begin
      in_wr = 1'b0;
      wa.push_back(la);
      wd.push_back(dq);
      cmd(la[11:0], dq[7:0]);
    end
  // timer runs when deselected
  always #20 if (left > 0) left = left - 1;
  assign ready = left == 0;
  // drive only selected and gated
  assign q_oe = !ce_n && !oe_n && we_n;
  // held till address, mode, select or gate moves
  always @(a or idm or oe_n or ce_n)
    q = idm ? {8'h00, ID_CODE} : mem.exists(int'(a)) ? mem[int'(a)] : ~a[15:0];
endmodule
`default_nettype wire

// *** verif/fbci_tb_top.sv ***
/*
  flash_bus_command_interface_tb_top: directed bench for fbci_host.
  assumes the flash model on the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_bus_command_interface_tb_top;
  import fbci_pkg::*;
  localparam logic [7:0] ID = 8'h5e; // arbitrary value
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic ce_n, we_n, oe_n, rst_n, hv, wide, top_o, top_oe, dq_oe, m_oe, rdy;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-2:0] dq_o;
  logic [DATA_W-1:0] m_q;
  wire [DATA_W-1:0] bus;
  wire [DATA_W-1:0] idle_q = {8{clk, ~clk}}; // floating
  int n_fail = 0;
  int check_count = 0;
  assign bus[14:0] = dq_oe ? dq_o : m_oe ? m_q[14:0] : idle_q[14:0];
  assign bus[15] = top_oe ? top_o : (m_oe && wide) ? m_q[15] : idle_q[15];
  initial forever #10 clk = ~clk;
  fbci_host dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n),
    .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_reset_n(rst_n), .flash_reset_hv(hv),
    .flash_wide(wide), .flash_a(fa), .shared_top_pin_o(top_o), .shared_top_pin_oe(top_oe),
    .shared_top_pin_i(bus[15]), .flash_dq_i(bus[14:0]), .flash_dq_o(dq_o),
    .flash_dq_oe(dq_oe), .flash_ready(rdy));
  fbci_flash_model #(.ID_CODE(ID)) flash (.ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
    .reset_hv(hv), .wide(wide), .a(fa), .dq(bus), .q(m_q), .q_oe(m_oe), .ready(rdy));
  task automatic complete_run();
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // data stands one cycle
  task automatic rd(logic [3:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // bounded busy poll
  task automatic idle(logic want_rdy);
    logic [31:0] s;
    int i;
    if (!want_rdy)
    begin
      // bus cycles only; an embedded op keeps busy set
      repeat (120) @(posedge clk);
      return;
    end
    for (i = 0; i < 500; i++)
    begin
      rd(REG_STATUS, s);
      if (s[STAT_BUSY_BIT] === 1'b0 && (!want_rdy || rdy === 1'b1)) break;
    end
    if (i == 500)
    begin
      n_fail++;
      complete_run();
    end
  endtask
  task automatic op(logic [2:0] o, logic [17:0] a, logic [15:0] d, logic w, logic want_rdy);
    flash.wa.delete();
    flash.wd.delete();
    wr(REG_ADDR, 32'(a));
    wr(REG_WDATA, 32'(d));
    wr(REG_CTRL, {26'h0, 1'b0, w, 1'b1, o});
    idle(want_rdy);
  endtask
  // unlock prefix check
  task automatic seq(int n, logic [7:0] c, logic w);
    logic [11:0] ua;
    for (int i = 0; i < n; i++)
    begin
      ua = (i % 3 == 1) ? (w ? 12'h2aa : 12'h555) : (w ? 12'h555 : 12'haaa);
      chk(32'({flash.wa[i][11:0], flash.wd[i][7:0]}),
        32'({ua, (i == 2) ? c : (i % 3 != 0) ? 8'h55 : 8'haa}));
    end
  endtask
  task automatic t_reset();
    logic [31:0] v;
    chk(32'({rst_n, wide, ce_n, we_n, oe_n, dq_oe}), 32'h3e);
    rd(REG_STATUS, v);
    chk(v, 32'h0);
    rd(4'hf, v); // unmapped
    chk(v, 32'h0);
  endtask
  task automatic t_prog(logic w);
    logic [31:0] v;
    op(OP_PROGRAM, 18'h01234, 16'hbeef, w, 1'b1);
    chk(32'(flash.wa.size()), 32'h4);
    seq(3, 8'ha0, w);
    chk(32'({flash.wa[3], flash.wd[3][7:0]}), 32'({18'h01234, 8'hef}));
    if (!w) return;
    op(OP_READ, 18'h01234, 16'h0, 1'b1, 1'b1);
    rd(REG_RDATA, v);
    chk(v, 32'hbeef);
  endtask
  task automatic t_ident();
    logic [31:0] v;
    op(OP_AUTOSELECT, 18'h00001, 16'h0, 1'b1, 1'b1);
    chk(32'(flash.wa.size()), 32'h3);
    seq(3, 8'h90, 1'b1);
    rd(REG_RDATA, v);
    chk(32'(v[7:0]), 32'(ID));
    rd(REG_STATUS, v);
    chk(32'(v[STAT_ASEL_BIT]), 32'h1);
    op(OP_RESET, 18'h0, 16'h0, 1'b1, 1'b1);
    chk(32'({flash.wa.size(), flash.wd[0][7:0]}), 32'h1f0);
    op(OP_READ, 18'h01234, 16'h0, 1'b1, 1'b1);
    rd(REG_RDATA, v);
    chk(v, 32'hbeef);
  endtask
  task automatic t_erase(logic [2:0] o);
    op(o, 18'h2c000, 16'h0, 1'b1, 1'b1);
    chk(32'(flash.wa.size()), 32'h6);
    seq(5, 8'h80, 1'b1);
    if (o == OP_CHIP_ERASE)
      chk(32'({flash.wa[5][11:0], flash.wd[5][7:0]}), 32'h55510);
    else
      chk(32'({flash.wa[5], flash.wd[5][7:0]}), 32'({18'h2c000, 8'h30}));
  endtask
  task automatic t_susp();
    logic [31:0] v;
    op(OP_SECTOR_ERASE, 18'h2c000, 16'h0, 1'b1, 1'b0);
    op(OP_RESET, 18'h0, 16'h0, 1'b1, 1'b0);
    rd(REG_STATUS, v);
    chk(32'({flash.wa.size(), v[STAT_ERR_BIT]}), 32'h1);
    wr(REG_STATUS, 32'h2);
    op(OP_SUSPEND, 18'h0, 16'h0, 1'b1, 1'b0);
    chk(32'({flash.wd[0][7:0], rdy}), 32'h161);
    rd(REG_STATUS, v);
    chk(32'(v[STAT_ERSUSP_BIT]), 32'h1);
    op(OP_RESUME, 18'h0, 16'h0, 1'b1, 1'b1);
    rd(REG_STATUS, v);
    chk(32'({flash.wd[0][7:0], v[STAT_ERSUSP_BIT]}), 32'h60);
  endtask
  // refused suspend and resume
  task automatic t_refuse();
    logic [31:0] v;
    for (int i = 0; i < 2; i++)
    begin
      op(i ? OP_RESUME : OP_SUSPEND, 18'h0, 16'h0, 1'b1, 1'b1);
      rd(REG_STATUS, v);
      chk(32'({flash.wa.size(), v[STAT_ERR_BIT]}), 32'h1);
      wr(REG_STATUS, 32'h2);
    end
    rd(REG_STATUS, v);
    chk(32'(v[STAT_ERR_BIT]), 32'h0);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_prog(1'b1);
    t_ident();
    t_prog(1'b0);
    t_erase(OP_CHIP_ERASE);
    t_erase(OP_SECTOR_ERASE);
    t_susp();
    t_refuse();
    complete_run();
  end
endmodule
`default_nettype wire
